// >>> rtl/rxig_cfg.svh
// register offsets, field positions and reset values of the receiver and interrupt gate block
`ifndef RXIG_CFG_SVH
`define RXIG_CFG_SVH
`define RXIG_ADDR_W 8
`define RXIG_DATA_W 8
`define RXIG_OFS_IRQ_MASTER_EN_LOW 8'h60
`define RXIG_OFS_RX_ON_UPPER 8'h88
`define RXIG_OFS_CHAN_IRQ_STATUS 8'h61
`define RXIG_FIELD_LSB 0
`define RXIG_FIELD_W 6
`define RXIG_RST_IRQ_MASTER_EN 6'h00
`define RXIG_RST_RX_ON 6'h00
`endif

// >>> rtl/rxig_pkg.sv
// types shared by the receiver and interrupt gate block
package rxig_pkg;
  // register port request from the host
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rxig_req_t;
  // per-channel line pin drive state for the receivers
  typedef struct packed {
    logic [5:0] rx_on;
    logic [5:0] hiz;
  } rxig_rx_t;
endpackage : rxig_pkg

// >>> rtl/rxig_top.sv
// receiver enable register, channel interrupt master gate and level status
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "rxig_cfg.svh"

module rxig_top #(
  parameter int NCH = 6
) (
  input wire logic clk,
  input wire logic reset,
  input wire rxig_pkg::rxig_req_t req,
  input wire logic [NCH-1:0] src_irq_pending,
  input wire logic [NCH-1:0] src_status_read,
  output logic [7:0] rdata,
  output rxig_pkg::rxig_rx_t rx_ctrl,
  output logic [NCH-1:0] chan_status,
  output logic host_irq
);
  import rxig_pkg::*;

  // stored enables, reset to off
  logic [NCH-1:0] rx_on_reg; // receivers of channels 11..6
  logic [NCH-1:0] master_en_reg; // master gates of channels 5..0
  logic [NCH-1:0] status_reg; // sticky channel level status
  logic [NCH-1:0] status_next;
  logic [7:0] rdata_next;
  logic irq_next;

  // receiver enable register write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_on_reg <= `RXIG_RST_RX_ON;
    end else if (req.wr && req.addr == `RXIG_OFS_RX_ON_UPPER) begin
      rx_on_reg <= req.wdata[NCH-1:0];
    end
  end

  // master interrupt enable register write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      master_en_reg <= `RXIG_RST_IRQ_MASTER_EN;
    end else if (req.wr && req.addr == `RXIG_OFS_IRQ_MASTER_EN_LOW) begin
      master_en_reg <= req.wdata[NCH-1:0];
    end
  end

  // per channel sticky status; a new event wins over the clearing read
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      always_comb begin
        // source pending already carries its own source enable
        if (master_en_reg[g] && src_irq_pending[g]) begin
          status_next[g] = 1'b1;
        end else if (src_status_read[g]) begin
          status_next[g] = 1'b0;
        end else begin
          status_next[g] = status_reg[g] & master_en_reg[g];
        end
      end
    end
  endgenerate

  // status update
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // host interrupt is the or of gated status
  assign irq_next = |status_next;

  // registered host interrupt pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      host_irq <= 1'b0;
    end else begin
      host_irq <= irq_next;
    end
  end

  // receiver pin control from the stored bits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_ctrl <= '{rx_on: `RXIG_RST_RX_ON, hiz: ~`RXIG_RST_RX_ON};
    end else begin
      rx_ctrl.rx_on <= rx_on_reg;
      rx_ctrl.hiz <= ~rx_on_reg;
    end
  end

  // status visible as output
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chan_status <= '0;
    end else begin
      chan_status <= status_next;
    end
  end

  // read mux, reserved bits and unmapped read zero
  always_comb begin
    rdata_next = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `RXIG_OFS_RX_ON_UPPER: rdata_next = {2'b00, rx_on_reg};
        `RXIG_OFS_IRQ_MASTER_EN_LOW: rdata_next = {2'b00, master_en_reg};
        `RXIG_OFS_CHAN_IRQ_STATUS: rdata_next = {2'b00, status_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // registered read data, zero in every cycle that follows no read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_next;
    end
  end

  // a channel masked in one cycle holds no status in the next
  property p_block;
    @(posedge clk) disable iff (reset)
      ((status_reg & ~$past(master_en_reg)) == '0);
  endproperty
  a_block: assert property (p_block) else $error("masked channel set status");

  // enabled pending source raises host irq next cycle
  property p_raise;
    @(posedge clk) disable iff (reset)
      (master_en_reg[0] && src_irq_pending[0]) |=> host_irq;
  endproperty
  a_raise: assert property (p_raise) else $error("host irq not raised");

  // status holds without a read
  property p_stick;
    @(posedge clk) disable iff (reset)
      (status_reg[0] && master_en_reg[0] && !src_status_read[0]
        && !(req.wr && req.addr == `RXIG_OFS_IRQ_MASTER_EN_LOW)) |=> status_reg[0];
  endproperty
  a_stick: assert property (p_stick) else $error("status dropped early");

  // write of the receiver enable register
  sequence s_rx_wr;
    req.wr && req.addr == `RXIG_OFS_RX_ON_UPPER;
  endsequence

  // receiver write reaches pins two cycles later
  property p_rx;
    @(posedge clk) disable iff (reset)
      s_rx_wr |=> ##1
        (rx_ctrl.rx_on == $past(req.wdata[5:0], 2));
  endproperty
  a_rx: assert property (p_rx) else $error("receiver enable mismatch");

  // off receiver is high impedance
  property p_hiz;
    @(posedge clk) disable iff (reset) rx_ctrl.hiz == ~rx_ctrl.rx_on;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin state mismatch");

  // write to and plain read of the master enable register
  sequence s_master_wr;
    req.wr && req.addr == `RXIG_OFS_IRQ_MASTER_EN_LOW;
  endsequence
  sequence s_master_rd;
    req.rd && !req.wr && req.addr == `RXIG_OFS_IRQ_MASTER_EN_LOW;
  endsequence

  // master write readback, reserved bits dropped
  property p_mrd;
    @(posedge clk) disable iff (reset)
      s_master_wr ##1 s_master_rd |=> rdata == {2'b00, $past(req.wdata[5:0], 2)};
  endproperty
  a_mrd: assert property (p_mrd) else $error("master readback wrong");

  // reserved bits always read zero
  property p_res;
    @(posedge clk) disable iff (reset) rdata[7:6] == 2'b00;
  endproperty
  a_res: assert property (p_res) else $error("reserved bits nonzero");

  // read clears status when no new event
  property p_clr;
    @(posedge clk) disable iff (reset)
      (src_status_read[0] && !src_irq_pending[0]) |=> !status_reg[0];
  endproperty
  a_clr: assert property (p_clr) else $error("status not cleared");

  // no master bit set keeps the host interrupt low
  property p_quiet;
    @(posedge clk) disable iff (reset)
      (master_en_reg == '0) |=> !host_irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("host irq with all channels masked");

  // enabled pending source shows in channel status and host irq
  property p_chan;
    @(posedge clk) disable iff (reset)
      (master_en_reg[2] && src_irq_pending[2]) |=> (chan_status[2] && host_irq);
  endproperty
  a_chan: assert property (p_chan) else $error("channel status not raised");

  // receiver on state follows the stored bits one cycle later
  property p_on;
    @(posedge clk) disable iff (reset)
      (rx_ctrl.rx_on == $past(rx_on_reg));
  endproperty
  a_on: assert property (p_on) else $error("receiver state lags register");

endmodule : rxig_top

// >>> verif/rxig_src_model.sv
// per-channel source interrupt logic seen by the gate
`timescale 1ns/100ps
module rxig_src_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] src_en,
  input wire logic [5:0] event_in,
  input wire logic [5:0] status_read,
  output logic [5:0] pending
);
  logic [5:0] flag_reg; // latched source events
  // events latch only when enabled, a status read clears them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_reg <= 6'h00;
    end else begin
      flag_reg <= (flag_reg & ~status_read) | (event_in & src_en);
    end
  end
  // the source enable also gates the level seen by the channel gate
  assign pending = flag_reg & src_en;
endmodule : rxig_src_model

// >>> verif/tb_top.sv
// self-checking bench for the receiver and interrupt gate registers
`timescale 1ns/100ps
module tb_top;
  import rxig_pkg::*;
  logic clk = 1'b0; // 10 MHz clock
  logic reset = 1'b1; // async reset
  rxig_req_t req = '0; // register port request
  logic [5:0] src_en = 6'h00; // source level enables
  logic [5:0] ev = 6'h00; // source event pulses
  logic [5:0] st_rd = 6'h00; // source status reads
  logic [5:0] pend;
  logic [7:0] rdata;
  rxig_rx_t rx_ctrl;
  logic [5:0] chan_status;
  logic host_irq;
  int err_count = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  rxig_top DUT (.clk(clk), .reset(reset), .req(req), .src_irq_pending(pend),
    .src_status_read(st_rd), .rdata(rdata), .rx_ctrl(rx_ctrl),
    .chan_status(chan_status), .host_irq(host_irq));
  rxig_src_model SRC (.clk(clk), .reset(reset), .src_en(src_en),
    .event_in(ev), .status_read(st_rd), .pending(pend));
  // verdict and end of run
  task finish_test;
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // compare seen against expected
  task chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write, called right after an edge; the strobe is left up
  // so that a following request can replace it with no gap
  task wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
  endtask : wr
  // one-cycle read; data are taken at the second edge, before it updates
  task rd(input logic [7:0] a, input logic [7:0] exp);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    chk({4'h0, rdata}, {4'h0, exp});
  endtask : rd
  // release the port and let some edges pass
  task idle(input int n);
    req <= '0;
    repeat (n) @(posedge clk);
  endtask : idle
  // source event with given source enables, then settle
  task fire(input logic [5:0] en, input logic [5:0] e);
    src_en <= en;
    ev <= e;
    @(posedge clk);
    ev <= 6'h00;
    repeat (3) @(posedge clk);
  endtask : fire
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(8'h88, 8'h00);
    chk(rx_ctrl, 12'h03F);
    wr(8'h88, 8'hFF);
    rd(8'h88, 8'h3F);
    chk(rx_ctrl, 12'hFC0);
    wr(8'h88, 8'h15);
    rd(8'h88, 8'h15);
    chk(rx_ctrl, 12'h56A);
    wr(8'h60, 8'hC5);
    rd(8'h60, 8'h05);
    rd(8'h70, 8'h00);
    fire(6'h3F, 6'h02);
    chk({chan_status, 5'h00, host_irq}, 12'h000);
    fire(6'h3E, 6'h01);
    chk({chan_status, 5'h00, host_irq}, 12'h000);
    fire(6'h3F, 6'h01);
    chk({chan_status, 5'h00, host_irq}, 12'h041);
    // source enable dropped: the pending level goes, the status must stay
    src_en <= 6'h3E;
    repeat (4) @(posedge clk);
    chk({chan_status, 5'h00, host_irq}, 12'h041);
    st_rd <= 6'h03;
    @(posedge clk);
    st_rd <= 6'h00;
    repeat (2) @(posedge clk);
    chk({chan_status, 5'h00, host_irq}, 12'h000);
    fire(6'h3F, 6'h04);
    chk({chan_status, 5'h00, host_irq}, 12'h101);
    wr(8'h60, 8'h00);
    idle(3);
    chk({chan_status, 5'h00, host_irq}, 12'h000);
    finish_test();
  end
  // watchdog against a hang
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule : tb_top
